/* core/timer2_counter.sv */
// Timer 2 counter core with prescaler control register
`timescale 1ns/1ps
module timer2_counter (
  input  wire logic       clock,
  input  wire logic       rst,
  input  wire logic [7:0] io_addr,
  input  wire logic       io_space,
  input  wire logic       io_wr,
  input  wire logic       io_rd,
  input  wire logic [7:0] io_wdata,
  output logic      [7:0] io_rdata,
  input  wire logic       counter_wr,
  input  wire logic [7:0] counter_wdata,
  input  wire logic       compare_a_wr,
  input  wire logic       compare_b_wr,
  input  wire logic [7:0] compare_wdata,
  input  wire logic [2:0] waveform_mode_field,
  input  wire logic [2:0] clock_select_field,
  input  wire logic       async_clock_select,
  input  wire logic       timer_power_reduction_bit,
  input  wire logic       crystal_pin_in,
  output logic            crystal_pin_out,
  input  wire logic [2:0] flag_clear,
  input  wire logic [2:0] irq_ack,
  input  wire logic [2:0] irq_mask_reg,
  output logic      [2:0] irq_flag_reg,
  output logic      [2:0] irq_req,
  output logic      [7:0] counter_value,
  output logic      [7:0] compare_reg_a,
  output logic      [7:0] compare_reg_b,
  output logic            top_hit,
  output logic            bottom_hit,
  output logic            max_hit,
  output logic            timer_tick,
  output logic            shared_prescaler_reset,
  output logic            async_prescaler_reset
);

  // ------------------------------------------------------------
  // Control register decode
  // ------------------------------------------------------------
  logic       sync_hold_mode;
  logic       async_pend_reg;
  logic       release_reg;
  logic       gtc_hit;
  logic       gtc_wr;
  logic [7:0] gtc_value;
  logic       xtal_reg;
  logic       xtal_rise;

  // Short I/O form sees the register below the data-space address
  always_comb begin
    if (io_space && io_addr == timer2_pkg::GTC_IO_ADDR) begin // see RQ1
      gtc_hit = 1'b1;
    end else if (!io_space && io_addr == timer2_pkg::GTC_DATA_ADDR) begin // see RQ1
      gtc_hit = 1'b1;
    end else begin
      gtc_hit = 1'b0;
    end
  end

  assign gtc_wr = io_wr && gtc_hit;
  assign gtc_value = {sync_hold_mode, 5'h00, async_prescaler_reset, shared_prescaler_reset};

  always_ff @(posedge clock) begin
    if (rst) begin
      io_rdata <= timer2_pkg::GTC_RESET;
    end else if (io_rd) begin
      io_rdata <= gtc_hit ? gtc_value : 8'h00;
    end
  end

  // ------------------------------------------------------------
  // Sync mode and prescaler reset bits
  // ------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (rst) begin
      sync_hold_mode <= 1'b0;
    end else if (gtc_wr) begin
      sync_hold_mode <= io_wdata[timer2_pkg::SYNC_MODE_BIT]; // see RQ2
    end
  end

  // Leaving sync mode waits for a pending async reset so both release together
  always_ff @(posedge clock) begin
    if (rst) begin
      release_reg <= 1'b0;
    end else if (gtc_wr && sync_hold_mode && !io_wdata[timer2_pkg::SYNC_MODE_BIT]) begin
      release_reg <= 1'b1; // see RQ23
    end else if (!async_pend_reg) begin
      release_reg <= 1'b0;
    end
  end

  // Async reset done once the crystal domain has taken an edge under reset
  always_ff @(posedge clock) begin
    if (rst) begin
      async_pend_reg <= 1'b0;
    end else if (gtc_wr && io_wdata[timer2_pkg::ASYNC_RST_BIT] && async_clock_select) begin
      async_pend_reg <= 1'b1; // see RQ5
    // A pending flag outliving its reset bit would stall the shared release
    end else if (xtal_rise || !async_clock_select || !async_prescaler_reset) begin
      async_pend_reg <= 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      async_prescaler_reset  <= 1'b0;
      shared_prescaler_reset <= 1'b0;
    end else if (gtc_wr && sync_hold_mode && !io_wdata[timer2_pkg::SYNC_MODE_BIT]) begin
      // Bits stay up one more cycle, longer while an async reset is pending, and drop together
      async_prescaler_reset  <= async_prescaler_reset | io_wdata[timer2_pkg::ASYNC_RST_BIT]; // see RQ3
      shared_prescaler_reset <= shared_prescaler_reset | io_wdata[timer2_pkg::SHARED_RST_BIT]; // see RQ3
    end else if (gtc_wr) begin
      async_prescaler_reset  <= io_wdata[timer2_pkg::ASYNC_RST_BIT]; // see RQ2
      shared_prescaler_reset <= io_wdata[timer2_pkg::SHARED_RST_BIT]; // see RQ2
    end else if (!sync_hold_mode) begin // see RQ6
      if (!async_pend_reg) begin
        async_prescaler_reset <= 1'b0; // see RQ4
      end
      if (!(release_reg && async_pend_reg)) begin
        shared_prescaler_reset <= 1'b0; // see RQ7
      end
    end
  end

  // ------------------------------------------------------------
  // Clock source and prescaler
  // ------------------------------------------------------------
  logic                             base_tick;
  logic [timer2_pkg::PRESC_W-1:0]   presc_reg;
  logic [timer2_pkg::PRESC_W-1:0]   tap_mask;

  always_ff @(posedge clock) begin
    if (rst) begin
      xtal_reg        <= 1'b0;
      crystal_pin_out <= 1'b1;
    end else begin
      xtal_reg        <= crystal_pin_in;
      crystal_pin_out <= !crystal_pin_in;
    end
  end

  assign xtal_rise = crystal_pin_in && !xtal_reg;
  assign base_tick = async_clock_select ? xtal_rise : 1'b1; // see RQ12
  assign tap_mask  = timer2_pkg::PRESC_MASK[clock_select_field];

  always_ff @(posedge clock) begin
    if (rst || async_prescaler_reset) begin
      presc_reg <= '0; // see RQ4
    end else if (base_tick) begin
      presc_reg <= presc_reg + 10'h001;
    end
  end

  // Held async reset halts the timer so synced timers start on one edge
  assign timer_tick = timer_power_reduction_bit // see RQ8
                   && clock_select_field != timer2_pkg::CS_STOP // see RQ13
                   && !async_prescaler_reset && base_tick
                   && (presc_reg & tap_mask) == tap_mask;

  // ------------------------------------------------------------
  // Mode decode and compare registers
  // ------------------------------------------------------------
  timer2_pkg::wave_mode_t mode;
  logic       phase_mode;
  logic       fast_mode;
  logic       pwm_mode;
  logic [7:0] top_value;
  logic [7:0] buf_a_reg;
  logic [7:0] buf_b_reg;
  logic       dir_reg;
  logic       count_down;
  logic       at_top;
  logic       reload;

  assign mode       = timer2_pkg::wave_mode_t'(waveform_mode_field); // see RQ16
  assign phase_mode = mode == timer2_pkg::WM_PHASE_MAX || mode == timer2_pkg::WM_PHASE_OCRA;
  assign fast_mode  = mode == timer2_pkg::WM_FAST_MAX || mode == timer2_pkg::WM_FAST_OCRA;
  assign pwm_mode   = phase_mode || fast_mode;
  assign top_value  = (mode == timer2_pkg::WM_CTC || mode == timer2_pkg::WM_PHASE_OCRA
                       || mode == timer2_pkg::WM_FAST_OCRA) ? compare_reg_a : timer2_pkg::CNT_MAX; // see RQ11
  assign at_top     = counter_value == top_value;
  assign top_hit    = at_top; // see RQ11
  assign bottom_hit = counter_value == timer2_pkg::CNT_BOTTOM; // see RQ10
  assign max_hit    = counter_value == timer2_pkg::CNT_MAX; // see RQ10
  // Phase modes turn round at top and at bottom
  assign count_down = phase_mode && (dir_reg ? !bottom_hit : at_top); // see RQ14
  assign reload     = pwm_mode && timer_tick && at_top && !dir_reg;

  always_ff @(posedge clock) begin
    if (rst) begin
      buf_a_reg <= 8'h00;
      buf_b_reg <= 8'h00;
    end else begin
      if (compare_a_wr) begin
        buf_a_reg <= compare_wdata;
      end
      if (compare_b_wr) begin
        buf_b_reg <= compare_wdata;
      end
    end
  end

  // Buffered copy lands at top so no odd-length pulse appears
  always_ff @(posedge clock) begin
    if (rst) begin
      compare_reg_a <= 8'h00; // see RQ9
      compare_reg_b <= 8'h00;
    end else if (!pwm_mode) begin
      if (compare_a_wr) begin
        compare_reg_a <= compare_wdata; // see RQ21
      end
      if (compare_b_wr) begin
        compare_reg_b <= compare_wdata; // see RQ21
      end
    end else if (reload) begin
      compare_reg_a <= buf_a_reg; // see RQ21
      compare_reg_b <= buf_b_reg; // see RQ21
    end
  end

  // ------------------------------------------------------------
  // Counter
  // ------------------------------------------------------------
  logic clear_now;
  logic block_reg;

  assign clear_now = (mode == timer2_pkg::WM_CTC || fast_mode) && at_top;

  always_ff @(posedge clock) begin
    if (rst) begin
      counter_value <= timer2_pkg::CNT_BOTTOM;
    end else if (counter_wr) begin
      counter_value <= counter_wdata; // see RQ15
    end else if (timer_tick) begin
      if (clear_now) begin
        counter_value <= timer2_pkg::CNT_BOTTOM; // see RQ14
      end else if (count_down) begin
        counter_value <= counter_value - 8'h01; // see RQ14
      end else begin
        counter_value <= counter_value + 8'h01; // see RQ22
      end
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      dir_reg <= 1'b0;
    end else if (!phase_mode) begin
      dir_reg <= 1'b0;
    end else if (timer_tick && !counter_wr) begin
      dir_reg <= count_down;
    end
  end

  // A counter write masks the match on the following tick
  always_ff @(posedge clock) begin
    if (rst) begin
      block_reg <= 1'b0;
    end else if (counter_wr) begin
      block_reg <= 1'b1;
    end else if (timer_tick) begin
      block_reg <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // Flags
  // ------------------------------------------------------------
  logic [2:0] flag_set;
  logic       ovf_event;

  always_comb begin
    if (mode == timer2_pkg::WM_NORMAL || mode == timer2_pkg::WM_CTC) begin
      ovf_event = max_hit; // see RQ22
    end else if (fast_mode) begin
      ovf_event = at_top; // see RQ18
    end else if (phase_mode) begin
      ovf_event = bottom_hit; // see RQ18
    end else begin
      ovf_event = 1'b0;
    end
  end

  always_comb begin
    flag_set = 3'h0;
    if (timer_tick && !counter_wr) begin
      flag_set[timer2_pkg::FLAG_OVF]   = ovf_event; // see RQ18
      flag_set[timer2_pkg::FLAG_CMP_A] = !block_reg && counter_value == compare_reg_a; // see RQ17
      flag_set[timer2_pkg::FLAG_CMP_B] = !block_reg && counter_value == compare_reg_b; // see RQ17
    end
  end

  // A set in the same cycle as a clear wins
  always_ff @(posedge clock) begin
    if (rst) begin
      irq_flag_reg <= 3'h0;
    end else begin
      irq_flag_reg <= (irq_flag_reg & ~(flag_clear | irq_ack)) | flag_set; // see RQ20
    end
  end

  assign irq_req = irq_flag_reg & irq_mask_reg; // see RQ19

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  chk_io_decode: assert property (@(posedge clock) disable iff (rst) // see RQ1
    io_wr && io_space && io_addr == timer2_pkg::GTC_IO_ADDR && io_wdata[timer2_pkg::SYNC_MODE_BIT]
    |=> sync_hold_mode)
    else $error("short I/O write did not reach control register");

  chk_hold_kept: assert property (@(posedge clock) disable iff (rst) // see RQ6
    sync_hold_mode && !io_wr |=> $stable(async_prescaler_reset) && $stable(shared_prescaler_reset))
    else $error("reset bit moved while sync mode held");

  chk_release_both: assert property (@(posedge clock) disable iff (rst) // see RQ3
    gtc_wr && sync_hold_mode && !io_wdata[timer2_pkg::SYNC_MODE_BIT] && !async_pend_reg
    && !io_wdata[timer2_pkg::ASYNC_RST_BIT] |=> ##1
    !shared_prescaler_reset && !async_prescaler_reset)
    else $error("leaving sync mode did not clear reset bits");

  chk_shared_clr: assert property (@(posedge clock) disable iff (rst) // see RQ7
    shared_prescaler_reset && !sync_hold_mode && !release_reg && !io_wr |=> !shared_prescaler_reset)
    else $error("shared reset bit not cleared");

  chk_async_hold: assert property (@(posedge clock) disable iff (rst) // see RQ5
    async_pend_reg && !gtc_wr |-> async_prescaler_reset || sync_hold_mode)
    else $error("async reset bit dropped before completion");

  chk_stop_tick: assert property (@(posedge clock) disable iff (rst) // see RQ13
    clock_select_field == timer2_pkg::CS_STOP || !timer_power_reduction_bit |-> !timer_tick)
    else $error("timer ticked while stopped or disabled");

  chk_write_prio: assert property (@(posedge clock) disable iff (rst) // see RQ15
    counter_wr |=> counter_value == $past(counter_wdata))
    else $error("counter write lost to count");

  chk_normal_wrap: assert property (@(posedge clock) disable iff (rst) // see RQ22
    mode == timer2_pkg::WM_NORMAL && timer_tick && !counter_wr && counter_value == timer2_pkg::CNT_MAX
    |=> counter_value == timer2_pkg::CNT_BOTTOM && irq_flag_reg[timer2_pkg::FLAG_OVF])
    else $error("normal mode wrap without overflow flag");

  chk_cmp_flag: assert property (@(posedge clock) disable iff (rst) // see RQ20
    timer_tick && !counter_wr && !block_reg && counter_value == compare_reg_a
    |=> irq_flag_reg[timer2_pkg::FLAG_CMP_A])
    else $error("compare A flag not set after match");

endmodule // timer2_counter

/* core/timer2_pkg.sv */
// Constants and types for the timer 2 counter core and prescaler control
// ----------------------------------------------------------------------
// Notes on behaviour
// RQ1: Control register at 0x43, short I/O 0x23.
// RQ2: Sync mode keeps written reset bits asserted.
// RQ3: Clearing sync mode clears both reset bits.
// RQ4: Async reset bit holds third prescaler reset.
// RQ5: Async mode: bit stays until reset done.
// RQ6: No async auto-clear while sync mode set.
// RQ7: Shared reset bit auto-clears unless sync mode.
// RQ8: Power bit one enables the timer.
// RQ9: Counter and compare registers are 8-bit.
// RQ10: Bottom at 0x00, max at 0xFF.
// RQ11: Top is max or compare A by mode.
// RQ12: Clock from I/O clock or crystal.
// RQ13: Clock select zero stops the timer.
// RQ14: Clear, increment or decrement per timer tick.
// RQ15: CPU counter write beats clear and count.
// RQ16: Mode from two A bits, one B bit.
// RQ17: Compare both channels, match sets flag.
// RQ18: Overflow flag set per waveform mode.
// RQ19: All flags visible, each gated by mask.
// RQ20: Compare flag next tick; write-one clears.
// RQ21: Compare double buffering only in PWM modes.
// RQ22: Normal mode overflow flag as counter wraps.
// RQ23: Both prescaler resets release on one edge.
// ----------------------------------------------------------------------
package timer2_pkg;
  localparam logic [7:0] GTC_DATA_ADDR = 8'h43;
  localparam logic [7:0] IO_SPACE_OFS  = 8'h20;
  localparam logic [7:0] GTC_IO_ADDR   = GTC_DATA_ADDR - IO_SPACE_OFS;
  localparam logic [7:0] GTC_RESET     = 8'h00;
  localparam int         SYNC_MODE_BIT = 7;
  localparam int         ASYNC_RST_BIT = 1;
  localparam int         SHARED_RST_BIT = 0;
  localparam logic [7:0] CNT_BOTTOM    = 8'h00;
  localparam logic [7:0] CNT_MAX       = 8'hff;
  localparam logic [2:0] CS_STOP       = 3'h0;
  localparam int         FLAG_OVF      = 0;
  localparam int         FLAG_CMP_A    = 1;
  localparam int         FLAG_CMP_B    = 2;
  localparam int         PRESC_W       = 10;
  localparam logic [9:0] PRESC_MASK [8] = '{10'h000, 10'h000, 10'h007, 10'h01f,
                                          10'h03f, 10'h07f, 10'h0ff, 10'h3ff};

  typedef enum logic [2:0] {
    WM_NORMAL     = 3'h0,
    WM_PHASE_MAX  = 3'h1,
    WM_CTC        = 3'h2,
    WM_FAST_MAX   = 3'h3,
    WM_RSVD4      = 3'h4,
    WM_PHASE_OCRA = 3'h5,
    WM_RSVD6      = 3'h6,
    WM_FAST_OCRA  = 3'h7
  } wave_mode_t;
endpackage

/* bench/testbench.sv */
// Self-checking bench for the timer 2 counter core and prescaler control register
`timescale 1ns/1ps
module testbench;
  logic       clock = 1'b0, rst = 1'b1, io_space = 1'b0, io_wr = 1'b0, io_rd = 1'b0;
  logic       counter_wr = 1'b0, compare_a_wr = 1'b0, compare_b_wr = 1'b0;
  logic       async_clock_select = 1'b0, timer_power_reduction_bit = 1'b1, crystal_pin_in = 1'b0;
  logic       crystal_pin_out, top_hit, bottom_hit, max_hit, timer_tick;
  logic       shared_prescaler_reset, async_prescaler_reset;
  logic [7:0] io_addr = 8'h00, io_wdata = 8'h00, counter_wdata = 8'h00, compare_wdata = 8'h00;
  logic [7:0] io_rdata, counter_value, compare_reg_a, compare_reg_b, snap;
  logic [2:0] waveform_mode_field = 3'h0, clock_select_field = 3'h0;
  logic [2:0] flag_clear = 3'h0, irq_ack = 3'h0, irq_mask_reg = 3'h0, irq_flag_reg, irq_req;
  int         fail_count = 0, compares = 0, k;

  always #50 clock = ~clock;

  timer2_counter i_timer2_counter (
    .clock, .rst, .io_addr, .io_space, .io_wr, .io_rd, .io_wdata, .io_rdata,
    .counter_wr, .counter_wdata, .compare_a_wr, .compare_b_wr, .compare_wdata,
    .waveform_mode_field, .clock_select_field, .async_clock_select,
    .timer_power_reduction_bit, .crystal_pin_in, .crystal_pin_out, .flag_clear,
    .irq_ack, .irq_mask_reg, .irq_flag_reg, .irq_req, .counter_value, .compare_reg_a,
    .compare_reg_b, .top_hit, .bottom_hit, .max_hit, .timer_tick,
    .shared_prescaler_reset, .async_prescaler_reset
  );

  // ------------------------------------------------------------
  // Access tasks
  // ------------------------------------------------------------
  // Sample 1 ns after the edge so registered outputs have settled
  task automatic step(input int n = 1);
    repeat (n) @(posedge clock);
    #1;
  endtask

  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic reg_wr(input logic sp, input logic [7:0] a, input logic [7:0] d);
    io_space <= sp;
    io_addr <= a;
    io_wdata <= d;
    io_wr <= 1'b1;
    step();
    io_wr <= 1'b0;
  endtask

  task automatic reg_rd(input logic sp, input logic [7:0] a, input logic [7:0] exp);
    io_space <= sp;
    io_addr <= a;
    io_rd <= 1'b1;
    step();
    io_rd <= 1'b0;
    check("register read", exp, io_rdata);
    step();
  endtask

  task automatic cnt_wr(input logic [7:0] d);
    counter_wdata <= d;
    counter_wr <= 1'b1;
    step();
    counter_wr <= 1'b0;
  endtask

  task automatic cmp_wr(input logic chan_b, input logic [7:0] d);
    compare_wdata <= d;
    compare_a_wr <= !chan_b;
    compare_b_wr <= chan_b;
    step();
    compare_a_wr <= 1'b0;
    compare_b_wr <= 1'b0;
    // Idle cycle so a following call does not re-raise a strobe in the same step
    step();
  endtask

  // Flags go either by write-one or by the interrupt being taken
  task automatic clr(input logic [2:0] f, input logic by_ack);
    if (by_ack) irq_ack <= f;
    else flag_clear <= f;
    step();
    irq_ack <= 3'h0;
    flag_clear <= 3'h0;
  endtask

  task automatic tally_and_finish();
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // ------------------------------------------------------------
  // Test sequence
  // ------------------------------------------------------------
  initial begin
    step(8);
    rst <= 1'b0;
    step();
    reg_rd(1'b0, 8'h43, 8'h00);
    reg_rd(1'b1, 8'h23, 8'h00);
    reg_wr(1'b0, 8'h23, 8'h83);
    reg_rd(1'b0, 8'h23, 8'h00);
    for (k = 0; k < 2; k++) begin
      reg_wr(1'b1, 8'h23, 8'(8'h01 << k));
      check("reset bit set", 8'(8'h01 << k), {6'h0, async_prescaler_reset, shared_prescaler_reset});
      step();
      check("reset bit cleared", 8'h00, {6'h0, async_prescaler_reset, shared_prescaler_reset});
    end
    cnt_wr(8'hfe);
    step(5);
    check("stopped count", 8'hfe, counter_value);
    check("no tick stopped", 8'h00, {7'h0, timer_tick});
    timer_power_reduction_bit <= 1'b0;
    clock_select_field <= 3'h1;
    step(5);
    check("disabled count", 8'hfe, counter_value);
    timer_power_reduction_bit <= 1'b1;
    for (k = 0; k < 10 && counter_value !== 8'hff; k++) step();
    check("max level", 8'h01, {7'h0, max_hit});
    check("top in normal mode", 8'h01, {7'h0, top_hit});
    step();
    check("wrapped count", 8'h00, counter_value);
    check("tick each cycle", 8'h01, {7'h0, timer_tick});
    check("bottom level", 8'h01, {7'h0, bottom_hit});
    check("overflow flag", 8'h01, {7'h0, irq_flag_reg[0]});
    check("masked request", 8'h00, {5'h0, irq_req});
    irq_mask_reg <= 3'h1;
    step();
    check("unmasked request", 8'h01, {7'h0, irq_req[0]});
    clr(3'h1, 1'b0);
    check("overflow cleared", 8'h00, {7'h0, irq_flag_reg[0]});
    cnt_wr(8'h40);
    check("write beats count", 8'h40, counter_value);
    step();
    check("count up", 8'h41, counter_value);
    cmp_wr(1'b0, 8'h50);
    check("compare a direct", 8'h50, compare_reg_a);
    cmp_wr(1'b1, 8'h60);
    check("compare b direct", 8'h60, compare_reg_b);
    irq_mask_reg <= 3'h6;
    clr(3'h7, 1'b0);
    for (k = 0; k < 300 && irq_flag_reg[1] !== 1'b1; k++) step();
    check("match a timing", 8'h51, counter_value);
    check("request a", 8'h02, {5'h0, irq_req});
    for (k = 0; k < 300 && irq_flag_reg[2] !== 1'b1; k++) step();
    check("match b timing", 8'h61, counter_value);
    clr(3'h6, 1'b1);
    check("ack clears", 8'h00, {5'h0, irq_flag_reg & 3'h6});
    waveform_mode_field <= 3'h2;
    for (k = 0; k < 300 && top_hit !== 1'b1; k++) step();
    check("top is compare a", 8'h50, counter_value);
    step();
    check("clear at top", 8'h00, counter_value);
    waveform_mode_field <= 3'h3;
    cmp_wr(1'b0, 8'h20);
    check("compare a buffered", 8'h50, compare_reg_a);
    for (k = 0; k < 300 && compare_reg_a !== 8'h20; k++) step();
    check("reload at top", 8'h00, counter_value);
    check("compare a reloaded", 8'h20, compare_reg_a);
    reg_wr(1'b0, 8'h43, 8'h83);
    snap = counter_value;
    step(3);
    check("held count", snap, counter_value);
    reg_rd(1'b1, 8'h23, 8'h83);
    reg_wr(1'b1, 8'h23, 8'h00);
    check("release together", 8'h03, {6'h0, async_prescaler_reset, shared_prescaler_reset});
    step();
    check("bits cleared", 8'h00, {6'h0, async_prescaler_reset, shared_prescaler_reset});
    waveform_mode_field <= 3'h0;
    async_clock_select <= 1'b1;
    reg_wr(1'b0, 8'h43, 8'h02);
    step(3);
    check("async reset pending", 8'h01, {7'h0, async_prescaler_reset});
    crystal_pin_in <= 1'b1;
    for (k = 0; k < 4 && async_prescaler_reset !== 1'b0; k++) step();
    check("async reset done", 8'h00, {7'h0, async_prescaler_reset});
    check("crystal out", 8'h00, {7'h0, crystal_pin_out});
    crystal_pin_in <= 1'b0;
    step(3);
    snap = counter_value;
    step(3);
    check("no edge no tick", snap, counter_value);
    crystal_pin_in <= 1'b1;
    step(3);
    check("tick on crystal edge", snap + 8'h01, counter_value);
    async_clock_select <= 1'b0;
    clock_select_field <= 3'h2;
    step();
    snap = counter_value;
    // Any 16 edges hold exactly two divide-by-eight ticks
    step(16);
    check("divide by eight", snap + 8'h02, counter_value);
    tally_and_finish();
  end

  // About 600 cycles of tests; 20000 cycles leaves ample margin
  initial begin
    #2000000;
    fail_count++;
    tally_and_finish();
  end
endmodule // testbench
